// >>> oec_pkg.sv
// Shared constants and types for the operating-mode and expansion control
// Notes on behaviour
// - Basic mode taken from mode pin two clocks before reset release.
// - Software configuration bits pick the memory configuration within a mode.
// - Single-chip mode uses no external bus; all port pins are I/O.
// - Expansion mode drives the bus while on-chip memories stay enabled.
// - With expansion, port A carries data, ports B and C the address.
// - Port D carries bus control; in expansion mode unused port D pins stay I/O.
// - Unclaimed pins in expansion mode stay individually programmable I/O.
// - Address and data sit on separate pins, never multiplexed.
// - Chip-select outputs are pre-decoded and active low.
// - Bank scheme drives five enabled bank selects from address decode.
// - Strobe scheme drives one data strobe for external accesses.
// - Microprocessor mode claims ports A to D regardless of software.
// - Microprocessor mode keeps RAM and EEPROM; memory-disable bit set disables program memory.
// - Without program memory, code and vectors come from external memory.
// - Both microprocessor configurations share the same bus behaviour.
// - Memory-disable bit at zero enables program memory in processor mode.
// - Microcomputer mode lets software set every expansion pin as I/O.
// - Both low-power modes stop instruction execution.
// - Standby keeps oscillator and timer running.
// - Halt stops oscillator, timers and all pin activity.
// - Low-power modes keep memory and configuration state unchanged.
// - After reset one automatic wait state makes accesses three clocks long.
package oec_pkg;

	// ----------------------------------------------------------------
	// Mode and timing constants
	// ----------------------------------------------------------------
	localparam logic MODE_UC = 1'b0;
	localparam logic MODE_UP = 1'b1;
	localparam int MODE_SAMPLE_LEAD = 2;
	localparam logic [1:0] ACC_LEN_BASE = 2'h2;
	localparam logic [1:0] ACC_LEN_AUTO = 2'h3;
	localparam logic SCHEME_BANK = 1'b0;
	localparam logic SCHEME_STROBE = 1'b1;

	// ----------------------------------------------------------------
	// Chip-select windows on address bits 15..12
	// ----------------------------------------------------------------
	localparam logic [3:0] WIN_E1_BASE = 4'h2;
	localparam logic [3:0] WIN_E1_MASK = 4'hE;
	localparam logic [3:0] WIN_E2_BASE = 4'h4;
	localparam logic [3:0] WIN_E2_MASK = 4'hE;
	localparam logic [3:0] WIN_H3_BASE = 4'h6;
	localparam logic [3:0] WIN_H3_MASK = 4'hE;
	localparam logic [3:0] WIN_H1_BASE = 4'h8;
	localparam logic [3:0] WIN_H1_MASK = 4'hC;
	localparam logic [3:0] WIN_H2_BASE = 4'hC;
	localparam logic [3:0] WIN_H2_MASK = 4'hC;

	// ----------------------------------------------------------------
	// Port D pin positions and claim masks
	// ----------------------------------------------------------------
	localparam int PD_CS_E2 = 0;
	localparam int PD_CS_H3 = 1;
	localparam int PD_CS_H2 = 2;
	localparam int PD_RW = 4;
	localparam int PD_CS_H1 = 6;
	localparam int PD_CS_E1 = 7;
	localparam int PD_EDS = 6;
	localparam int PD_WAIT = 7;
	localparam logic [7:0] PD_MASK_BANK = 8'hD7;
	localparam logic [7:0] PD_MASK_STROBE = 8'hD0;
	localparam logic [7:0] PD_MASK_ALL = 8'hFF;
	localparam logic [7:0] BYTE_ONES = 8'hFF;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] c;
		logic [7:0] d;
	} oec_port_t;

	typedef struct packed {
		oec_port_t dout;
		oec_port_t dir;
	} oec_gpio_t;

	typedef enum logic [1:0] {
		LP_RUN = 2'b00,
		LP_STANDBY = 2'b01,
		LP_HALT = 2'b10
	} oec_lp_t;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_ACC = 2'b01,
		SEQ_DONE = 2'b10
	} oec_seq_t;

endpackage

// >>> oec_mode_latch.sv
// Basic-mode capture from the mode-select pin at reset release
`timescale 1ns/1ps
module oec_mode_latch (
	// Clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Strap
	input wire logic mode_select_pin_i,
	// Latched mode
	output logic mode_o
);

	logic [oec_pkg::MODE_SAMPLE_LEAD-1:0] hist_r;
	logic taken_r;
	logic mode_r;

	// Pin history, free running so the value two clocks back is known
	always_ff @(posedge clock_i) begin
		hist_r <= {hist_r[oec_pkg::MODE_SAMPLE_LEAD-2:0], mode_select_pin_i};
	end

	// Capture once at the first edge after release, then hold
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			taken_r <= 1'b0;
			mode_r <= oec_pkg::MODE_UC;
		end else if (!taken_r) begin
			taken_r <= 1'b1;
			mode_r <= hist_r[oec_pkg::MODE_SAMPLE_LEAD-1];
		end
	end

	assign mode_o = mode_r;

endmodule // oec_mode_latch

// >>> oec_bus_seq.sv
// External access sequencer with automatic and pin-driven wait states
`timescale 1ns/1ps
module oec_bus_seq (
	// Clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Control
	input wire logic start_i,
	input wire logic auto_wait_i,
	input wire logic wait_n_i,
	// Status
	output logic acc_nxt_o,
	output logic fin_o,
	output logic busy_o,
	output logic done_o
);

	oec_pkg::oec_seq_t state_r, state_nxt;
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	logic [1:0] len;

	// Access length in clocks
	assign len = auto_wait_i ? oec_pkg::ACC_LEN_AUTO
		: oec_pkg::ACC_LEN_BASE;
	assign fin_o = (state_r == oec_pkg::SEQ_ACC) &&
		(cnt_r >= len - 2'h1) && wait_n_i;

	// Next state
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		case (state_r)
			oec_pkg::SEQ_IDLE: begin
				cnt_nxt = 2'h0;
				if (start_i) begin
					state_nxt = oec_pkg::SEQ_ACC;
				end
			end
			oec_pkg::SEQ_ACC: begin
				if (fin_o) begin
					state_nxt = oec_pkg::SEQ_DONE;
				end else if (cnt_r < len - 2'h1) begin
					cnt_nxt = cnt_r + 2'h1;
				end
			end
			oec_pkg::SEQ_DONE: begin
				state_nxt = oec_pkg::SEQ_IDLE;
			end
			default: begin
				state_nxt = oec_pkg::SEQ_IDLE;
			end
		endcase
	end

	// State registers
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r <= oec_pkg::SEQ_IDLE;
			cnt_r <= 2'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign acc_nxt_o = (state_nxt == oec_pkg::SEQ_ACC);
	assign busy_o = (state_r != oec_pkg::SEQ_IDLE);
	assign done_o = (state_r == oec_pkg::SEQ_DONE);

endmodule // oec_bus_seq

// >>> oec_top.sv
// Operating-mode, expansion bus and low-power control
`timescale 1ns/1ps
module oec_top (
	// Clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Mode strap
	input wire logic mode_select_pin_i,
	// CPU side external access
	input wire logic ext_req_i,
	input wire logic ext_we_i,
	input wire logic [15:0] ext_addr_i,
	input wire logic [7:0] ext_wdata_i,
	output logic [7:0] ext_rdata_o,
	output logic ext_ack_o,
	output logic ext_busy_o,
	// Software configuration bits
	input wire logic expansion_en_i,
	input wire logic cs_scheme_i,
	input wire logic [4:0] bank_cs_en_i,
	input wire logic strobe_en_i,
	input wire logic mem_disable_i,
	input wire logic autowait_dis_i,
	input wire oec_pkg::oec_gpio_t gpio_i,
	// Low-power requests
	input wire logic standby_req_i,
	input wire logic halt_req_i,
	input wire logic wake_i,
	// Port pins
	input wire oec_pkg::oec_port_t pin_in_i,
	output oec_pkg::oec_port_t pin_out_o,
	output oec_pkg::oec_port_t pin_oe_n_o,
	output oec_pkg::oec_port_t gpio_in_o,
	// Status
	output logic mode_up_o,
	output logic bus_active_o,
	output logic rom_en_o,
	output logic ram_en_o,
	output logic eeprom_en_o,
	output logic vectors_ext_o,
	output logic cpu_run_o,
	output logic osc_en_o,
	output logic timer_en_o
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic mode_up;
	logic bus_active;
	logic pm_on;
	logic auto_wait_r;
	logic start;
	logic acc_nxt;
	logic fin;
	logic busy;
	logic done;
	logic wait_n;
	logic [15:0] addr_r;
	logic [15:0] addr_nxt;
	logic [7:0] wdata_r;
	logic [7:0] wdata_nxt;
	logic we_r;
	logic we_nxt;
	logic [7:0] rdata_r;
	logic ack_r;
	logic [4:0] cs_hit;
	logic [7:0] ctl_out;
	logic [7:0] ctl_oe_n;
	logic [7:0] d_mask;
	logic [7:0] abc_mask;
	oec_pkg::oec_lp_t lp_r, lp_nxt;
	oec_pkg::oec_port_t out_r, out_nxt;
	oec_pkg::oec_port_t oe_n_r, oe_n_nxt;
	oec_pkg::oec_port_t gin_r;
	logic mode_up_r;
	logic bus_active_r;
	logic rom_en_r;
	logic vec_ext_r;
	logic run_r;
	logic osc_r;
	logic tmr_r;

	// Address window hit on the top nibble
	function automatic logic in_win(input logic [15:0] addr,
		input logic [3:0] base, input logic [3:0] mask);
		in_win = ((addr[15:12] & mask) == base);
	endfunction

	// Merge bus-owned bits over software-owned bits
	function automatic logic [7:0] merge(input logic [7:0] claim,
		input logic [7:0] busv, input logic [7:0] gpv);
		merge = (claim & busv) | (~claim & gpv);
	endfunction

	// ----------------------------------------------------------------
	// Mode latch and access sequencer
	// ----------------------------------------------------------------
	oec_mode_latch u_mode (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.mode_select_pin_i(mode_select_pin_i),
		.mode_o(mode_up)
	);

	oec_bus_seq u_seq (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.start_i(start),
		.auto_wait_i(auto_wait_r),
		.wait_n_i(wait_n),
		.acc_nxt_o(acc_nxt),
		.fin_o(fin),
		.busy_o(busy),
		.done_o(done)
	);

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	// Bus owns the ports in processor mode or when expansion is enabled
	assign bus_active = (mode_up == oec_pkg::MODE_UP) ||
		expansion_en_i;
	// Program memory on in computer mode, or in processor mode when enabled
	assign pm_on = (mode_up == oec_pkg::MODE_UC) ||
		!mem_disable_i;
	// Accesses start only while running and the bus is owned
	assign start = ext_req_i && bus_active && !busy &&
		(lp_r == oec_pkg::LP_RUN);
	// Wait pin is an input only under the strobe scheme
	assign wait_n = (cs_scheme_i == oec_pkg::SCHEME_STROBE) ?
		gin_r.d[oec_pkg::PD_WAIT] : 1'b1;
	assign addr_nxt = start ? ext_addr_i : addr_r;
	assign we_nxt = start ? ext_we_i : we_r;
	assign wdata_nxt = start ? ext_wdata_i : wdata_r;

	// ----------------------------------------------------------------
	// Chip-select decode
	// ----------------------------------------------------------------
	// Pre-decoded windows, each gated by its enable bit
	assign cs_hit[0] = bank_cs_en_i[0] && in_win(addr_nxt,
		oec_pkg::WIN_E1_BASE, oec_pkg::WIN_E1_MASK);
	assign cs_hit[1] = bank_cs_en_i[1] && in_win(addr_nxt,
		oec_pkg::WIN_E2_BASE, oec_pkg::WIN_E2_MASK);
	assign cs_hit[2] = bank_cs_en_i[2] && in_win(addr_nxt,
		oec_pkg::WIN_H1_BASE, oec_pkg::WIN_H1_MASK);
	assign cs_hit[3] = bank_cs_en_i[3] && in_win(addr_nxt,
		oec_pkg::WIN_H2_BASE, oec_pkg::WIN_H2_MASK);
	assign cs_hit[4] = bank_cs_en_i[4] && in_win(addr_nxt,
		oec_pkg::WIN_H3_BASE, oec_pkg::WIN_H3_MASK);

	// Port D control bits for each scheme, active-low selects
	always_comb begin
		ctl_out = oec_pkg::BYTE_ONES;
		ctl_oe_n = oec_pkg::BYTE_ONES;
		ctl_out[oec_pkg::PD_RW] = !(acc_nxt && we_nxt);
		ctl_oe_n[oec_pkg::PD_RW] = 1'b0;
		if (cs_scheme_i == oec_pkg::SCHEME_BANK) begin
			ctl_out[oec_pkg::PD_CS_E1] = !(acc_nxt && cs_hit[0]);
			ctl_out[oec_pkg::PD_CS_E2] = !(acc_nxt && cs_hit[1]);
			ctl_out[oec_pkg::PD_CS_H1] = !(acc_nxt && cs_hit[2]);
			ctl_out[oec_pkg::PD_CS_H2] = !(acc_nxt && cs_hit[3]);
			ctl_out[oec_pkg::PD_CS_H3] = !(acc_nxt && cs_hit[4]);
			ctl_oe_n[oec_pkg::PD_CS_E1] = 1'b0;
			ctl_oe_n[oec_pkg::PD_CS_E2] = 1'b0;
			ctl_oe_n[oec_pkg::PD_CS_H1] = 1'b0;
			ctl_oe_n[oec_pkg::PD_CS_H2] = 1'b0;
			ctl_oe_n[oec_pkg::PD_CS_H3] = 1'b0;
		end else begin
			ctl_out[oec_pkg::PD_EDS] = !(acc_nxt && strobe_en_i);
			ctl_oe_n[oec_pkg::PD_EDS] = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Pin muxing
	// ----------------------------------------------------------------
	// Claims: processor mode takes every pin, expansion mode only bus pins
	assign abc_mask = bus_active ? oec_pkg::BYTE_ONES
		: oec_pkg::BYTE_ZERO;
	assign d_mask = (mode_up == oec_pkg::MODE_UP) ? oec_pkg::PD_MASK_ALL :
		!expansion_en_i ? oec_pkg::BYTE_ZERO :
		(cs_scheme_i == oec_pkg::SCHEME_BANK) ? oec_pkg::PD_MASK_BANK
		: oec_pkg::PD_MASK_STROBE;

	// Separate data and address pins, no multiplexing
	assign out_nxt.a = merge(abc_mask, wdata_nxt, gpio_i.dout.a);
	assign out_nxt.b = merge(abc_mask, addr_nxt[7:0], gpio_i.dout.b);
	assign out_nxt.c = merge(abc_mask, addr_nxt[15:8], gpio_i.dout.c);
	assign out_nxt.d = merge(d_mask, ctl_out, gpio_i.dout.d);
	// Data pins driven only while a write is on the bus
	assign oe_n_nxt.a = merge(abc_mask,
		{8{!(acc_nxt && we_nxt)}}, ~gpio_i.dir.a);
	assign oe_n_nxt.b = merge(abc_mask, oec_pkg::BYTE_ZERO, ~gpio_i.dir.b);
	assign oe_n_nxt.c = merge(abc_mask, oec_pkg::BYTE_ZERO, ~gpio_i.dir.c);
	assign oe_n_nxt.d = merge(d_mask, ctl_oe_n, ~gpio_i.dir.d);

	// ----------------------------------------------------------------
	// Low-power control
	// ----------------------------------------------------------------
	// Halt wins over standby; wake returns to run
	always_comb begin
		lp_nxt = lp_r;
		case (lp_r)
			oec_pkg::LP_RUN: begin
				if (halt_req_i && !busy) begin
					lp_nxt = oec_pkg::LP_HALT;
				end else if (standby_req_i && !busy) begin
					lp_nxt = oec_pkg::LP_STANDBY;
				end
			end
			oec_pkg::LP_STANDBY: begin
				if (wake_i) begin
					lp_nxt = oec_pkg::LP_RUN;
				end
			end
			oec_pkg::LP_HALT: begin
				if (wake_i) begin
					lp_nxt = oec_pkg::LP_RUN;
				end
			end
			default: begin
				lp_nxt = oec_pkg::LP_RUN;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lp_r <= oec_pkg::LP_RUN;
		end else begin
			lp_r <= lp_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Access registers
	// ----------------------------------------------------------------
	// Auto wait set by reset, then follows the software disable bit
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			auto_wait_r <= 1'b1;
		end else begin
			auto_wait_r <= !autowait_dis_i;
		end
	end

	// Request capture and read data at the last access clock
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			addr_r <= 16'h0000;
			wdata_r <= 8'h00;
			we_r <= 1'b0;
			rdata_r <= 8'h00;
			ack_r <= 1'b0;
		end else begin
			addr_r <= addr_nxt;
			we_r <= we_nxt;
			wdata_r <= wdata_nxt;
			if (fin && !we_r) begin
				rdata_r <= pin_in_i.a;
			end
			ack_r <= fin;
		end
	end

	// ----------------------------------------------------------------
	// Pin and status registers
	// ----------------------------------------------------------------
	// Pins freeze in halt so nothing toggles and state is kept
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			out_r <= '1;
			oe_n_r <= '1;
			gin_r <= '0;
		end else if (lp_r != oec_pkg::LP_HALT) begin
			out_r <= out_nxt;
			oe_n_r <= oe_n_nxt;
			gin_r <= pin_in_i;
		end
	end

	// Memory enables, vector source and clock gating
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_up_r <= oec_pkg::MODE_UC;
			bus_active_r <= 1'b0;
			rom_en_r <= 1'b1;
			vec_ext_r <= 1'b0;
			run_r <= 1'b0;
			osc_r <= 1'b1;
			tmr_r <= 1'b1;
		end else begin
			mode_up_r <= mode_up;
			bus_active_r <= bus_active;
			rom_en_r <= pm_on;
			vec_ext_r <= !pm_on;
			run_r <= (lp_nxt == oec_pkg::LP_RUN);
			osc_r <= (lp_nxt != oec_pkg::LP_HALT);
			tmr_r <= (lp_nxt != oec_pkg::LP_HALT);
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign ext_rdata_o = rdata_r;
	assign ext_ack_o = ack_r;
	assign ext_busy_o = busy;
	assign pin_out_o = out_r;
	assign pin_oe_n_o = oe_n_r;
	assign gpio_in_o = gin_r;
	assign mode_up_o = mode_up_r;
	assign bus_active_o = bus_active_r;
	assign rom_en_o = rom_en_r;
	assign ram_en_o = 1'b1;
	assign eeprom_en_o = 1'b1;
	assign vectors_ext_o = vec_ext_r;
	assign cpu_run_o = run_r;
	assign osc_en_o = osc_r;
	assign timer_en_o = tmr_r;

endmodule // oec_top

// >>> oec_chk.sv
// Concurrent checks on the ports of the mode and expansion control
`timescale 1ns/1ps
module oec_chk (
	// Clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Inputs that cause outputs
	input wire logic ext_we_i,
	input wire logic [15:0] ext_addr_i,
	input wire logic [7:0] ext_wdata_i,
	input wire logic cs_scheme_i,
	input wire logic [4:0] bank_cs_en_i,
	input wire logic mem_disable_i,
	input wire logic autowait_dis_i,
	input wire oec_pkg::oec_gpio_t gpio_i,
	// Observed outputs
	input wire logic ext_ack_o,
	input wire logic ext_busy_o,
	input wire oec_pkg::oec_port_t pin_out_o,
	input wire oec_pkg::oec_port_t pin_oe_n_o,
	input wire logic mode_up_o,
	input wire logic bus_active_o,
	input wire logic rom_en_o,
	input wire logic ram_en_o,
	input wire logic eeprom_en_o,
	input wire logic vectors_ext_o,
	input wire logic osc_en_o,
	input wire logic timer_en_o
);
	logic [1:0] rel_cnt_r;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!arst_n_i);

	// ----------------------------------------------------------------
	// Edges since reset release, saturating at three
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rel_cnt_r <= 2'h0;
		end else if (rel_cnt_r != 2'h3) begin
			rel_cnt_r <= rel_cnt_r + 2'h1;
		end
	end

	// ----------------------------------------------------------------
	// Mode and memory enables
	// ----------------------------------------------------------------
	AST_MODE_HOLD: assert property (
		rel_cnt_r == 2'h3 |-> $stable(mode_up_o))
		else $error("latched mode changed after reset");
	AST_MEM_ON: assert property (
		ram_en_o && eeprom_en_o)
		else $error("ram or eeprom disabled");
	AST_ROM_SEL: assert property (
		rel_cnt_r == 2'h3 && $stable(mem_disable_i) && $stable(mode_up_o)
		|-> rom_en_o == !(mode_up_o && mem_disable_i))
		else $error("program memory enable wrong");
	AST_VEC_EXT: assert property (
		rel_cnt_r == 2'h3 |-> vectors_ext_o == !rom_en_o)
		else $error("vector source disagrees with rom enable");
	AST_UP_CLAIM: assert property (
		rel_cnt_r == 2'h3 && mode_up_o |-> bus_active_o)
		else $error("processor mode without bus ownership");
	AST_GPIO_DIR: assert property (
		rel_cnt_r == 2'h3 && !bus_active_o && !$past(bus_active_o)
		&& osc_en_o && $past(osc_en_o)
		|-> pin_oe_n_o == ~$past(gpio_i.dir))
		else $error("pin enables do not follow software direction");

	// ----------------------------------------------------------------
	// Bus accesses
	// ----------------------------------------------------------------
	AST_WAIT_AUTO: assert property (
		$rose(ext_busy_o) && !autowait_dis_i && !$past(autowait_dis_i)
		&& !$past(autowait_dis_i, 2) && cs_scheme_i == oec_pkg::SCHEME_BANK
		|-> !ext_ack_o [*3] ##1 ext_ack_o)
		else $error("access with auto wait not three cycles");
	AST_WAIT_OFF: assert property (
		$rose(ext_busy_o) && autowait_dis_i && $past(autowait_dis_i)
		&& $past(autowait_dis_i, 2) && cs_scheme_i == oec_pkg::SCHEME_BANK
		|-> !ext_ack_o [*2] ##1 ext_ack_o)
		else $error("access without auto wait not two cycles");
	AST_ACK_ONE: assert property (
		ext_ack_o |=> !ext_ack_o)
		else $error("ack longer than one cycle");
	AST_BUS_PINS: assert property (
		$rose(ext_busy_o) |-> {pin_out_o.c, pin_out_o.b} == $past(ext_addr_i)
		&& {pin_oe_n_o.c, pin_oe_n_o.b} == 16'h0000
		&& pin_out_o.d[4] == !$past(ext_we_i))
		else $error("address or direction wrong on pins");
	AST_DATA_DIR: assert property (
		$rose(ext_busy_o) |-> pin_oe_n_o.a == ($past(ext_we_i) ? 8'h00 : 8'hFF)
		&& (!$past(ext_we_i) || pin_out_o.a == $past(ext_wdata_i)))
		else $error("data port drive wrong");
	AST_CS_E1: assert property (
		$rose(ext_busy_o) && cs_scheme_i == oec_pkg::SCHEME_BANK
		&& bank_cs_en_i[0] && $past(ext_addr_i[15:13]) == 3'h1
		|-> !pin_out_o.d[7] && !pin_oe_n_o.d[7])
		else $error("bank select e1 not asserted");
	AST_REFUSE: assert property (
		!bus_active_o && !ext_busy_o |=> !ext_busy_o || bus_active_o)
		else $error("access started without bus");
	AST_OSC_TMR: assert property (
		osc_en_o == timer_en_o)
		else $error("timer and oscillator disagree");
	AST_HALT_FRZ: assert property (
		!osc_en_o && !$past(osc_en_o)
		|-> $stable(pin_out_o) && $stable(pin_oe_n_o))
		else $error("pins moved during halt");
endmodule // oec_chk

bind oec_top oec_chk u_chk (.*);

// >>> oec_ext_mem.sv
// Model of external memory on the expansion bus, with optional wait
`timescale 1ns/1ps
module oec_ext_mem (
	// Clock
	input wire logic clock_i,
	// Pins driven by the device
	input wire oec_pkg::oec_port_t pin_out_i,
	input wire oec_pkg::oec_port_t pin_oe_n_i,
	// Bench control
	input wire logic stall_i,
	input wire oec_pkg::oec_port_t pins_i,
	// Levels seen by the device
	output oec_pkg::oec_port_t pin_in_o
);
	logic [7:0] mem_r [0:65535];
	logic [7:0] last_r = 8'h00;
	logic [1:0] sel_cnt_r = 2'h0;
	logic [15:0] addr;
	logic sel;
	logic rd;

	// Address taken straight off ports B and C, no latch
	assign addr = {pin_out_i.c, pin_out_i.b};
	// Any select or strobe driven low enables the chip
	assign sel = ~&(pin_out_i.d | pin_oe_n_i.d | 8'h38);
	assign rd = sel && pin_out_i.d[4] && (pin_oe_n_i.a == 8'hFF);

	// Released data lines toggle so stale values never look valid
	always_comb begin
		pin_in_o = pins_i;
		pin_in_o.a = rd ? mem_r[addr] : ~last_r;
		pin_in_o.d[7] = !(stall_i && sel && sel_cnt_r < 2'h2);
	end

	// Write capture and select-length count
	always @(posedge clock_i) begin
		last_r <= pin_in_o.a;
		sel_cnt_r <= sel ? ((sel_cnt_r == 2'h3) ? 2'h3 : sel_cnt_r + 2'h1) : 2'h0;
		if (sel && !pin_out_i.d[4] && pin_oe_n_i.a == 8'h00) begin
			mem_r[addr] <= pin_out_i.a;
		end
	end
endmodule // oec_ext_mem

// >>> oec_tb.sv
// Self-checking bench for the operating-mode and expansion control
`timescale 1ns/1ps
module tb;
	logic clock_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic mode_select_pin_i = 1'b0;
	logic ext_req_i = 1'b0;
	logic ext_we_i = 1'b0;
	logic [15:0] ext_addr_i = 16'h0000;
	logic [7:0] ext_wdata_i = 8'h00;
	logic expansion_en_i = 1'b0;
	logic cs_scheme_i = 1'b0;
	logic [4:0] bank_cs_en_i = 5'h1F;
	logic strobe_en_i = 1'b0;
	logic mem_disable_i = 1'b1;
	logic autowait_dis_i = 1'b0;
	logic standby_req_i = 1'b0;
	logic halt_req_i = 1'b0;
	logic wake_i = 1'b0;
	logic stall = 1'b0;
	oec_pkg::oec_gpio_t gpio_i = 64'h0;
	oec_pkg::oec_port_t pins_lvl = 32'h0;
	oec_pkg::oec_port_t pin_in_i, pin_out_o, pin_oe_n_o, gpio_in_o, held;
	logic [7:0] ext_rdata_o, rd;
	logic ext_ack_o, ext_busy_o, mode_up_o, bus_active_o, rom_en_o, ram_en_o;
	logic eeprom_en_o, vectors_ext_o, cpu_run_o, osc_en_o, timer_en_o;
	logic [3:0] win [5] = '{4'h2, 4'h4, 4'h6, 4'h8, 4'hC};
	int lat;
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;

	// ----------------------------------------------------------------
	// Device, external memory and clock
	// ----------------------------------------------------------------
	oec_top u_dut (.*);
	oec_ext_mem u_mem (.clock_i(clock_i), .pin_out_i(pin_out_o),
		.pin_oe_n_i(pin_oe_n_o), .stall_i(stall), .pins_i(pins_lvl),
		.pin_in_o(pin_in_i));
	initial begin
		forever #12.5 clock_i = ~clock_i;
	end

	// ----------------------------------------------------------------
	// Compare, access and reset tasks
	// ----------------------------------------------------------------
	task automatic cmp_bit(input string what, input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmp_byte(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmp_port(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One byte access; lat counts cycles to ack, 8 means no answer
	task automatic access(input logic we, input logic [15:0] a, input logic [7:0] d);
		@(negedge clock_i);
		ext_req_i = 1'b1;
		ext_we_i = we;
		ext_addr_i = a;
		ext_wdata_i = d;
		lat = 0;
		@(negedge clock_i);
		ext_req_i = 1'b0;
		while (ext_ack_o !== 1'b1 && lat < 8) begin
			@(negedge clock_i);
			lat++;
		end
		rd = ext_rdata_o;
		@(negedge clock_i);
	endtask
	// Reset with the strap flipped at release, then check the latch
	task automatic do_reset(input logic mv);
		arst_n_i = 1'b0;
		mode_select_pin_i = mv;
		repeat (20) @(negedge clock_i);
		mode_select_pin_i = ~mv;
		arst_n_i = 1'b1;
		repeat (3) @(negedge clock_i);
		cmp_bit("mode", mv, mode_up_o);
		repeat (4) @(negedge clock_i);
		cmp_bit("mode_late", mv, mode_up_o);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Cuts a hang short
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 4000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		gpio_i.dout = 32'h3C5AA5DF;
		gpio_i.dir = 32'h0FF0F028;
		pins_lvl.b = 8'h96;
		do_reset(1'b0);
		cmp_port("oe_n", ~gpio_i.dir, pin_oe_n_o);
		cmp_port("out", gpio_i.dout & gpio_i.dir, pin_out_o & gpio_i.dir);
		cmp_byte("gin_b", 8'h96, gpio_in_o.b);
		access(1'b1, 16'h2000, 8'h11);
		cmp_byte("lat_sc", 8'h08, lat[7:0]);
		cmp_bit("rom_uc", 1'b1, rom_en_o);
		expansion_en_i = 1'b1;
		for (int i = 0; i < 5; i++) begin
			access(1'b1, {win[i], 12'h345}, 8'h10 + 8'(i));
			cmp_byte("lat_wr", 8'h03, lat[7:0]);
		end
		for (int i = 0; i < 5; i++) begin
			access(1'b0, {win[i], 12'h345}, 8'h00);
			cmp_byte("rd_bank", 8'h10 + 8'(i), rd);
		end
		cmp_byte("pd_gpio", 8'h08, pin_out_o.d & 8'h28);
		cmp_byte("pd_oe", 8'hD7, pin_oe_n_o.d | 8'hD7);
		bank_cs_en_i = 5'h1E;
		access(1'b1, 16'h2345, 8'hEE);
		bank_cs_en_i = 5'h1F;
		access(1'b0, 16'h2345, 8'h00);
		cmp_byte("rd_cs_off", 8'h10, rd);
		autowait_dis_i = 1'b1;
		access(1'b0, 16'h4345, 8'h00);
		cmp_byte("lat_nowait", 8'h02, lat[7:0]);
		cs_scheme_i = 1'b1;
		strobe_en_i = 1'b1;
		access(1'b0, 16'h4345, 8'h00);
		cmp_byte("rd_strobe", 8'h11, rd);
		stall = 1'b1;
		access(1'b0, 16'h4345, 8'h00);
		cmp_bit("stretched", 1'b1, lat > 2 && lat < 8);
		stall = 1'b0;
		cs_scheme_i = 1'b0;
		autowait_dis_i = 1'b0;
		standby_req_i = 1'b1;
		repeat (2) @(negedge clock_i);
		standby_req_i = 1'b0;
		cmp_bit("run_sb", 1'b0, cpu_run_o);
		cmp_bit("osc_sb", 1'b1, osc_en_o & timer_en_o);
		access(1'b0, 16'h4345, 8'h00);
		cmp_byte("lat_sb", 8'h08, lat[7:0]);
		wake_i = 1'b1;
		@(negedge clock_i);
		wake_i = 1'b0;
		repeat (2) @(negedge clock_i);
		cmp_bit("run_wake", 1'b1, cpu_run_o);
		halt_req_i = 1'b1;
		repeat (2) @(negedge clock_i);
		halt_req_i = 1'b0;
		cmp_bit("osc_halt", 1'b0, osc_en_o | timer_en_o);
		held = pin_out_o;
		gpio_i.dout.d = 8'hD7;
		repeat (3) @(negedge clock_i);
		cmp_port("frozen", held, pin_out_o);
		wake_i = 1'b1;
		@(negedge clock_i);
		wake_i = 1'b0;
		repeat (3) @(negedge clock_i);
		cmp_bit("pd3_kept", 1'b0, pin_out_o.d[3]);
		expansion_en_i = 1'b0;
		gpio_i.dir = 32'h0;
		do_reset(1'b1);
		cmp_bit("bus_up", 1'b1, bus_active_o);
		cmp_byte("pb_oe_up", 8'h00, pin_oe_n_o.b);
		cmp_bit("rom_off", 1'b0, rom_en_o);
		cmp_bit("vec_ext", 1'b1, vectors_ext_o);
		access(1'b0, 16'h2345, 8'h00);
		cmp_byte("rd_up", 8'h10, rd);
		cmp_byte("lat_up", 8'h03, lat[7:0]);
		mem_disable_i = 1'b0;
		repeat (2) @(negedge clock_i);
		cmp_bit("rom_on", 1'b1, rom_en_o);
		cmp_bit("vec_int", 1'b0, vectors_ext_o);
		print_verdict();
	end
endmodule // tb
